// ### rtl/aux_input_sync_control.sv
// Interlock, transient trigger and external phase-lock logic
//
// Overview of operation
// - Interlock input has three behaviours: disabled, gating, forcing.
// - Disabled: interlock input ignored when enabling output.
// - Gating: enable requests honoured only while contacts closed; closure alone enables nothing.
// - Gating: contacts opening while output enabled raises a fault.
// - Forcing: closed contacts enable output regardless of enable command.
// - Gating setting: 1 selects the mode, 0 leaves it.
// - Forcing setting: 1 selects the mode, 0 leaves it.
// - Trigger honoured only with external triggering on and program launched; then armed.
// - Armed program starts on a trigger rising edge only.
// - Armed program reports running while waiting for the trigger.
// - Only phase A locks; B and C keep their angles to A.
// - Programmable fixed phase offset between reference and phase A.
// - Lock only within target frequency plus or minus window, default 10 Hz.
// - Generated frequency stays clamped inside window, even without reference.
// - Programmable tracking speed for the phase-lock loop.
// - Reference is rising-edge, 15 to 5000 Hz; source keeps within it.
// - Lock status output as locked or unlocked.
// - While locked, show locked indication one second of every three.
// - Not locked shows unlocked indication.
`timescale 1ns/10ps
module aux_input_sync_control #(
	parameter int unsigned REF_TIMEOUT = aux_input_pkg::REF_TIMEOUT_CYC,
	parameter int unsigned SHOW_ON     = aux_input_pkg::SHOW_ON_CYC,
	parameter int unsigned SHOW_PERIOD = aux_input_pkg::SHOW_PERIOD_CYC
) (
	input  wire logic        MCLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        INTERLOCK_INPUT_I,
	input  wire logic        TRANSIENT_START_INPUT_I,
	input  wire logic        SYNC_REF_I,
	input  wire logic        MODE_DISABLE_WR_I,
	input  wire logic        INTERLOCK_GATE_SETTING_WR_I,
	input  wire logic        INTERLOCK_GATE_SETTING_I,
	input  wire logic        INTERLOCK_FORCE_SETTING_WR_I,
	input  wire logic        INTERLOCK_FORCE_SETTING_I,
	input  wire logic        OUT_ON_REQ_I,
	input  wire logic        OUT_OFF_REQ_I,
	input  wire logic        FAULT_CLR_I,
	input  wire logic        EXT_TRIG_EN_I,
	input  wire logic        PROG_LAUNCH_I,
	input  wire logic        PROG_STOP_I,
	input  wire logic        SYNC_EN_I,
	input  wire logic [31:0] FREQUENCY_TARGET_I,
	input  wire logic        RANGE_WR_I,
	input  wire logic [31:0] RANGE_I,
	input  wire logic [3:0]  SPEED_I,
	input  wire logic [31:0] PHASE_OFFSET_SETTING_I,
	input  wire logic [15:0] PHASE_B_ANGLE_I,
	input  wire logic [15:0] PHASE_C_ANGLE_I,
	output logic             OUTPUT_ENABLE_O,
	output logic             FAULT_O,
	output logic             MODE_GATE_O,
	output logic             MODE_FORCE_O,
	output logic             PROG_RUNNING_O,
	output logic             PROG_WAIT_O,
	output logic             PROG_START_O,
	output logic [15:0]      PHASE_A_O,
	output logic [15:0]      PHASE_B_O,
	output logic [15:0]      PHASE_C_O,
	output logic [31:0]      FREQ_WORD_O,
	output logic             LOCKED_O,
	output logic             UNLOCKED_O,
	output logic             SYNC_SHOW_O
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers: bit 0 interlock, bit 1 trigger, bit 2 reference
	logic [2:0] s1_r, s2_r, s3_r;
	logic [2:0] s1_nxt, s2_nxt, s3_nxt;
	logic       closed, trig_rise, ref_rise;

	always_comb
	begin
		s1_nxt = {SYNC_REF_I, TRANSIENT_START_INPUT_I, INTERLOCK_INPUT_I};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
		end
		else
		begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	assign closed    = s2_r[0];
	assign trig_rise = s2_r[1] & ~s3_r[1];
	assign ref_rise  = s2_r[2] & ~s3_r[2];

	////////////////////////////////////////////////////////////////////////////////
	// Interlock mode and output enable
	aux_input_pkg::il_mode_t mode_r, mode_nxt;
	logic en_r, en_nxt, out_r, out_nxt, fault_r, fault_nxt;

	always_comb
	begin
		mode_nxt = mode_r;
		if (MODE_DISABLE_WR_I)
			mode_nxt = aux_input_pkg::IL_DISABLED;
		else if (INTERLOCK_GATE_SETTING_WR_I)
		begin
			if (INTERLOCK_GATE_SETTING_I)
				mode_nxt = aux_input_pkg::IL_GATE;
			else if (mode_r == aux_input_pkg::IL_GATE)
				mode_nxt = aux_input_pkg::IL_DISABLED;
		end
		else if (INTERLOCK_FORCE_SETTING_WR_I)
		begin
			if (INTERLOCK_FORCE_SETTING_I)
				mode_nxt = aux_input_pkg::IL_FORCE;
			else if (mode_r == aux_input_pkg::IL_FORCE)
				mode_nxt = aux_input_pkg::IL_DISABLED;
		end

		en_nxt    = en_r;
		fault_nxt = fault_r & ~FAULT_CLR_I;
		if (OUT_OFF_REQ_I)
			en_nxt = 1'b0;
		// A pending fault refuses enable until software clears it
		else if (OUT_ON_REQ_I && !fault_r &&
			(mode_r != aux_input_pkg::IL_GATE || closed))
			en_nxt = 1'b1;
		if (mode_r == aux_input_pkg::IL_GATE && en_r && !closed)
		begin
			en_nxt    = 1'b0;
			fault_nxt = 1'b1;
		end
		// Forcing does not latch: opening the contacts drops the output again
		out_nxt = en_nxt | (mode_r == aux_input_pkg::IL_FORCE && closed);
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			mode_r  <= aux_input_pkg::IL_DISABLED;
			en_r    <= 1'b0;
			out_r   <= 1'b0;
			fault_r <= 1'b0;
		end
		else
		begin
			mode_r  <= mode_nxt;
			en_r    <= en_nxt;
			out_r   <= out_nxt;
			fault_r <= fault_nxt;
		end
	end

	assign OUTPUT_ENABLE_O = out_r;
	assign FAULT_O         = fault_r;
	assign MODE_GATE_O     = (mode_r == aux_input_pkg::IL_GATE);
	assign MODE_FORCE_O    = (mode_r == aux_input_pkg::IL_FORCE);

	////////////////////////////////////////////////////////////////////////////////
	// Transient program start
	aux_input_pkg::tr_state_t tr_r, tr_nxt;
	logic start_r, start_nxt;

	always_comb
	begin
		tr_nxt    = tr_r;
		start_nxt = 1'b0;
		unique case (tr_r)
			aux_input_pkg::TR_IDLE:
				if (PROG_LAUNCH_I)
				begin
					if (EXT_TRIG_EN_I)
						tr_nxt = aux_input_pkg::TR_ARMED;
					else
					begin
						tr_nxt    = aux_input_pkg::TR_RUN;
						start_nxt = 1'b1;
					end
				end
			aux_input_pkg::TR_ARMED:
				if (trig_rise)
				begin
					tr_nxt    = aux_input_pkg::TR_RUN;
					start_nxt = 1'b1;
				end
			aux_input_pkg::TR_RUN:
				tr_nxt = tr_r;
		endcase
		if (PROG_STOP_I)
		begin
			tr_nxt    = aux_input_pkg::TR_IDLE;
			start_nxt = 1'b0;
		end
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			tr_r    <= aux_input_pkg::TR_IDLE;
			start_r <= 1'b0;
		end
		else
		begin
			tr_r    <= tr_nxt;
			start_r <= start_nxt;
		end
	end

	assign PROG_RUNNING_O = (tr_r != aux_input_pkg::TR_IDLE);
	assign PROG_WAIT_O    = (tr_r == aux_input_pkg::TR_ARMED);
	assign PROG_START_O   = start_r;

	////////////////////////////////////////////////////////////////////////////////
	// Phase-lock engine
	logic [31:0]              acc_r, acc_nxt, inc_r, inc_nxt, range_r, range_nxt;
	logic [15:0]              phb_r, phb_nxt, phc_r, phc_nxt;
	logic [aux_input_pkg::AGE_W-1:0]  age_r, age_nxt;
	logic [aux_input_pkg::DISP_W-1:0] disp_r, disp_nxt;
	logic [2:0]               lcnt_r, lcnt_nxt;
	logic                     show_r, show_nxt;
	logic                     edge_ok, lost, in_win, locked;
	logic signed [31:0]       err, step;
	logic [31:0]              err_abs;
	logic signed [33:0]       sum, lo, hi, held;

	localparam int unsigned DISP_W = aux_input_pkg::DISP_W;

	always_comb
	begin
		edge_ok = ref_rise && (age_r >= aux_input_pkg::REF_MIN_PER_CYC);
		lost    = (age_r >= REF_TIMEOUT);
		err     = $signed(acc_r - PHASE_OFFSET_SETTING_I);
		err_abs = err[31] ? 32'(-err) : 32'(err);
		step    = err >>> (4'hF - SPEED_I);
		lo      = $signed({2'h0, FREQUENCY_TARGET_I}) - $signed({2'h0, range_r});
		hi      = $signed({2'h0, FREQUENCY_TARGET_I}) + $signed({2'h0, range_r});
		sum     = $signed({2'h0, inc_r}) - $signed({{2{step[31]}}, step});
		in_win  = (sum >= lo) && (sum <= hi);
		held    = (sum < lo) ? lo : ((sum > hi) ? hi : sum);
		range_nxt = RANGE_WR_I ? RANGE_I : range_r;
		age_nxt   = edge_ok ? '0 : (lost ? age_r : age_r + 1'b1);

		// Clamp holds even between edges, so a lost reference cannot drift
		inc_nxt = inc_r;
		if (!SYNC_EN_I)
			inc_nxt = FREQUENCY_TARGET_I;
		else if (edge_ok)
			inc_nxt = held[31:0];
		else if ($signed({2'h0, inc_r}) < lo)
			inc_nxt = lo[31:0];
		else if ($signed({2'h0, inc_r}) > hi)
			inc_nxt = hi[31:0];
		acc_nxt = acc_r + inc_r;
		phb_nxt = acc_nxt[31:16] + PHASE_B_ANGLE_I;
		phc_nxt = acc_nxt[31:16] + PHASE_C_ANGLE_I;

		lcnt_nxt = lcnt_r;
		if (!SYNC_EN_I || lost)
			lcnt_nxt = 3'h0;
		else if (edge_ok)
		begin
			if (in_win && err_abs < aux_input_pkg::LOCK_TOL)
				lcnt_nxt = (lcnt_r == aux_input_pkg::LOCK_EDGES) ? lcnt_r : lcnt_r + 3'h1;
			else
				lcnt_nxt = 3'h0;
		end
		locked = (lcnt_r == aux_input_pkg::LOCK_EDGES);

		if (!locked || disp_r >= DISP_W'(SHOW_PERIOD - 1))
			disp_nxt = '0;
		else
			disp_nxt = disp_r + 1'b1;
		show_nxt = locked && (disp_r < DISP_W'(SHOW_ON));
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			acc_r   <= 32'h0;
			inc_r   <= 32'h0;
			range_r <= aux_input_pkg::RANGE_DEF_WORD;
			phb_r   <= 16'h0;
			phc_r   <= 16'h0;
			age_r   <= '0;
			lcnt_r  <= 3'h0;
			disp_r  <= '0;
			show_r  <= 1'b0;
		end
		else
		begin
			acc_r   <= acc_nxt;
			inc_r   <= inc_nxt;
			range_r <= range_nxt;
			phb_r   <= phb_nxt;
			phc_r   <= phc_nxt;
			age_r   <= age_nxt;
			lcnt_r  <= lcnt_nxt;
			disp_r  <= disp_nxt;
			show_r  <= show_nxt;
		end
	end

	assign PHASE_A_O   = acc_r[31:16];
	assign PHASE_B_O   = phb_r;
	assign PHASE_C_O   = phc_r;
	assign FREQ_WORD_O = inc_r;
	assign LOCKED_O    = (lcnt_r == aux_input_pkg::LOCK_EDGES);
	assign UNLOCKED_O  = (lcnt_r != aux_input_pkg::LOCK_EDGES);
	assign SYNC_SHOW_O = show_r;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	property p_gate_fault;
		mode_r == aux_input_pkg::IL_GATE && en_r && !closed |=> FAULT_O && !OUTPUT_ENABLE_O;
	endproperty
	a_gate_fault: assert property (p_gate_fault) else $error("gate open no fault");

	property p_gate_block;
		mode_r == aux_input_pkg::IL_GATE && !closed |=> !OUTPUT_ENABLE_O;
	endproperty
	a_gate_block: assert property (p_gate_block) else $error("gate open enabled");

	property p_force;
		mode_r == aux_input_pkg::IL_FORCE && closed |=> OUTPUT_ENABLE_O;
	endproperty
	a_force: assert property (p_force) else $error("force not enabled");

	property p_dis;
		mode_r == aux_input_pkg::IL_DISABLED && OUT_ON_REQ_I && !OUT_OFF_REQ_I && !FAULT_O
			|=> OUTPUT_ENABLE_O;
	endproperty
	a_dis: assert property (p_dis) else $error("disabled mode refused enable");

	property p_excl;
		INTERLOCK_GATE_SETTING_WR_I && INTERLOCK_GATE_SETTING_I && !MODE_DISABLE_WR_I
			|=> MODE_GATE_O && !MODE_FORCE_O;
	endproperty
	a_excl: assert property (p_excl) else $error("mode not exclusive");

	property p_arm;
		tr_r == aux_input_pkg::TR_IDLE && PROG_LAUNCH_I && EXT_TRIG_EN_I && !PROG_STOP_I
			|=> PROG_WAIT_O && PROG_RUNNING_O && !PROG_START_O;
	endproperty
	a_arm: assert property (p_arm) else $error("launch did not arm");

	property p_trig;
		PROG_WAIT_O && trig_rise && !PROG_STOP_I |=> PROG_START_O ##1 !PROG_START_O;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger edge not taken");

	property p_hold;
		PROG_WAIT_O && !trig_rise && !PROG_STOP_I |=> PROG_WAIT_O && !PROG_START_O;
	endproperty
	a_hold: assert property (p_hold) else $error("armed left without edge");

	property p_clamp;
		SYNC_EN_I && edge_ok |=> $signed({2'h0, inc_r}) >= $past(lo)
			&& $signed({2'h0, inc_r}) <= $past(hi);
	endproperty
	a_clamp: assert property (p_clamp) else $error("frequency outside window");

	property p_lost;
		lost || !SYNC_EN_I |=> UNLOCKED_O ##1 !SYNC_SHOW_O;
	endproperty
	a_lost: assert property (p_lost) else $error("lock kept without reference");

	property p_show;
		SYNC_SHOW_O |-> LOCKED_O || $past(LOCKED_O);
	endproperty
	a_show: assert property (p_show) else $error("locked shown while unlocked");

	c_trig:  cover property (PROG_WAIT_O ##[1:50] PROG_START_O);
	c_fault: cover property (MODE_GATE_O && OUTPUT_ENABLE_O ##[1:20] FAULT_O);
	c_force: cover property (MODE_FORCE_O && !en_r && OUTPUT_ENABLE_O);
	c_lock:  cover property (UNLOCKED_O ##1 LOCKED_O);

endmodule : aux_input_sync_control

// ### rtl/aux_input_pkg.sv
// Constants shared by the auxiliary dedicated-input block
package aux_input_pkg;

	// Clock and derived timing
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned REF_MIN_HZ    = 15;
	localparam int unsigned REF_MAX_HZ    = 5000;
	localparam int unsigned SHOW_ON_S     = 1;
	localparam int unsigned SHOW_PERIOD_S = 3;
	// Longest gap between reference edges before the reference counts as missing
	localparam int unsigned REF_TIMEOUT_CYC = (CLK_HZ + REF_MIN_HZ - 1) / REF_MIN_HZ;
	// Shortest acceptable gap between reference edges (highest frequency, rounded down)
	localparam int unsigned REF_MIN_PER_CYC = CLK_HZ / REF_MAX_HZ;
	localparam int unsigned SHOW_ON_CYC     = CLK_HZ * SHOW_ON_S;
	localparam int unsigned SHOW_PERIOD_CYC = CLK_HZ * SHOW_PERIOD_S;

	// Phase accumulator: one full turn is 2**32
	localparam int unsigned ACC_W          = 32;
	localparam int unsigned RANGE_DEF_HZ   = 10;
	localparam logic [31:0] RANGE_DEF_WORD =
		32'((64'(RANGE_DEF_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [31:0] LOCK_TOL       = 32'h0400_0000;
	localparam logic [2:0]  LOCK_EDGES     = 3'h4;

	// Counter widths
	localparam int unsigned AGE_W  = 22;
	localparam int unsigned DISP_W = 26;

	// Interlock behaviours
	typedef enum logic [1:0] {
		IL_DISABLED,
		IL_GATE,
		IL_FORCE
	} il_mode_t;

	// Transient program sequencing
	typedef enum logic [1:0] {
		TR_IDLE,
		TR_ARMED,
		TR_RUN
	} tr_state_t;

endpackage : aux_input_pkg

// ### verification/aux_input_far_side.sv
// Far-side model: interlock contacts, trigger pulse source and phase reference source
`timescale 1ns/10ps
module aux_input_far_side (
	input  wire logic        clk_i,
	input  wire logic        close_i,
	input  wire logic        trig_i,
	input  wire logic [15:0] period_i,
	output logic             interlock_o,
	output logic             trig_o,
	output logic             ref_o
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	initial
	begin
		cnt_r = 16'h0000;
		interlock_o = 1'b0;
		trig_o = 1'b0;
		ref_o = 1'b0;
	end
	// Period 0 stops the source; the line then idles low as a driven logic output
	always_comb
	begin
		cnt_nxt = cnt_r + 16'h0001;
		if (period_i == 16'h0000 || cnt_nxt >= period_i)
			cnt_nxt = 16'h0000;
	end
	always @(posedge clk_i)
	begin
		cnt_r       <= cnt_nxt;
		interlock_o <= close_i;
		trig_o      <= trig_i;
		// Periods from 4000 cycles up keep the source at or below 5000 Hz and, in 16 bits, above 15 Hz
		ref_o       <= (period_i != 16'h0000) && (cnt_r < (period_i >> 1));
	end
endmodule : aux_input_far_side

// ### verification/tb_aux_input_sync_control.sv
// Self-checking bench for the interlock, trigger and phase-lock block
`timescale 1ns/10ps
module tb_aux_input_sync_control;
	localparam int unsigned TMO = 20000;
	localparam int unsigned SON = 10;
	localparam int unsigned SPER = 30;
	localparam int unsigned CEIL = 95000;
	localparam logic [15:0] REF_PER = 16'h1194;
	// Tuning word of a 4500-cycle period: 2**32 / 4500
	localparam logic [31:0] TGT = 32'h000E_9045;
	localparam logic [10:0] DIS = 11'h400, GATE1 = 11'h300, FORCE1 = 11'h0C0, FORCE0 = 11'h080;
	localparam logic [10:0] ON = 11'h020, OFF = 11'h010, CLR = 11'h008, GO = 11'h004;
	localparam logic [10:0] HALT = 11'h002, RNGW = 11'h001;
	logic        clk, rst_n, md_wr, g_wr, g_v, f_wr, f_v, on_r, off_r, f_clr, launch, stop;
	logic        trg_en, sync_en, rng_wr, close, trig, mon, exp_en;
	logic        en, flt, m_g, m_f, run, wt, st, lk, ulk, show;
	logic [31:0] tgt, rng, ph_off, seed, offv, fw;
	logic [15:0] ang_b, ang_c, rper, pa, pb, pc;
	logic [3:0]  speed;
	wire logic   il, tt, sref;
	int          n_mismatch, tests_run, cyc, n, k;

	aux_input_far_side aux_input_far_side_inst (.clk_i(clk), .close_i(close), .trig_i(trig),
		.period_i(rper), .interlock_o(il), .trig_o(tt), .ref_o(sref));
	aux_input_sync_control #(.REF_TIMEOUT(TMO), .SHOW_ON(SON), .SHOW_PERIOD(SPER))
		aux_input_sync_control_inst (.MCLK_I(clk), .RST_N_I(rst_n), .INTERLOCK_INPUT_I(il),
		.TRANSIENT_START_INPUT_I(tt), .SYNC_REF_I(sref), .MODE_DISABLE_WR_I(md_wr),
		.INTERLOCK_GATE_SETTING_WR_I(g_wr), .INTERLOCK_GATE_SETTING_I(g_v),
		.INTERLOCK_FORCE_SETTING_WR_I(f_wr), .INTERLOCK_FORCE_SETTING_I(f_v),
		.OUT_ON_REQ_I(on_r), .OUT_OFF_REQ_I(off_r), .FAULT_CLR_I(f_clr), .EXT_TRIG_EN_I(trg_en),
		.PROG_LAUNCH_I(launch), .PROG_STOP_I(stop), .SYNC_EN_I(sync_en),
		.FREQUENCY_TARGET_I(tgt), .RANGE_WR_I(rng_wr), .RANGE_I(rng), .SPEED_I(speed),
		.PHASE_OFFSET_SETTING_I(ph_off), .PHASE_B_ANGLE_I(ang_b), .PHASE_C_ANGLE_I(ang_c),
		.OUTPUT_ENABLE_O(en), .FAULT_O(flt), .MODE_GATE_O(m_g), .MODE_FORCE_O(m_f),
		.PROG_RUNNING_O(run), .PROG_WAIT_O(wt), .PROG_START_O(st), .PHASE_A_O(pa),
		.PHASE_B_O(pb), .PHASE_C_O(pc), .FREQ_WORD_O(fw), .LOCKED_O(lk), .UNLOCKED_O(ulk),
		.SYNC_SHOW_O(show));

	////////////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// Underflow of the lower bound is not guarded: targets stay well above the range
	function automatic logic in_win(input logic [31:0] f, input logic [31:0] t,
		input logic [31:0] r);
		return (f >= t - r) && (f <= t + r);
	endfunction : in_win
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One-cycle strobe of the control pulses; outputs are sampled once the answer edge lands
	task automatic pulse(input logic [10:0] v);
		@(posedge clk);
		{md_wr, g_wr, g_v, f_wr, f_v, on_r, off_r, f_clr, launch, stop, rng_wr} <= v;
		@(posedge clk);
		{md_wr, g_wr, g_v, f_wr, f_v, on_r, off_r, f_clr, launch, stop, rng_wr} <= 11'h000;
		#1;
	endtask : pulse
	task automatic pin(input logic c, input logic t);
		@(posedge clk);
		close <= c;
		trig <= t;
	endtask : pin
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : idle
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == CEIL)
		begin
			n_mismatch++;
			wrap_up();
		end
	end
	always @(negedge clk)
		if (mon)
		begin
			check("freq_window", {31'h0, in_win(fw, tgt, rng)}, 32'h1);
			check("phase_b", {16'h0, pb}, {16'h0, pa + ang_b});
			check("phase_c", {16'h0, pc}, {16'h0, pa + ang_c});
		end

	initial
	begin
		{md_wr, g_wr, g_v, f_wr, f_v, on_r, off_r, f_clr, launch, stop, rng_wr} = 11'h000;
		{rst_n, trg_en, sync_en, close, trig, mon} = 6'h00;
		{n_mismatch, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
		seed = xs(32'hAC44);
		ang_b = seed[15:0];
		ang_c = seed[31:16];
		{tgt, rng, ph_off, rper, speed} = {TGT, 32'h0000_2000, 32'h0, 16'h0, 4'h4};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		idle(1);
		check("rst_state", {26'h0, en, flt, m_g, m_f, run, ulk}, 32'h1);
		exp_en = 1'b0;
		// Random requests with random contacts: disabled mode never looks at the contacts
		for (k = 0; k < 24; k++)
		begin
			seed = xs(seed);
			pin(seed[0], 1'b0);
			pulse({5'h00, seed[1], seed[2], 4'h0});
			exp_en = seed[2] ? 1'b0 : (seed[1] ? 1'b1 : exp_en);
			check("en_disabled", en, exp_en);
		end
		pulse(OFF);
		pulse(GATE1);
		check("gate_mode", {m_g, m_f}, 2'b10);
		pin(1'b0, 1'b0);
		idle(5);
		pulse(ON);
		check("en_open", en, 1'b0);
		pin(1'b1, 1'b0);
		idle(6);
		check("en_closed_only", en, 1'b0);
		pulse(ON);
		check("en_gated", en, 1'b1);
		pin(1'b0, 1'b0);
		idle(5);
		check("fault_en", {flt, en}, 2'b10);
		pin(1'b1, 1'b0);
		idle(5);
		pulse(ON);
		check("en_in_fault", en, 1'b0);
		pulse(CLR);
		pulse(ON);
		check("en_cleared", {flt, en}, 2'b01);
		pulse(OFF);
		pin(1'b0, 1'b0);
		pulse(FORCE1);
		check("force_mode", {m_g, m_f}, 2'b01);
		idle(5);
		pin(1'b1, 1'b0);
		idle(1);
		check("en_sync_lag", en, 1'b0);
		idle(5);
		check("en_forced", en, 1'b1);
		pin(1'b0, 1'b0);
		idle(5);
		check("en_force_open", en, 1'b0);
		pulse(FORCE0);
		check("force_off", {m_g, m_f}, 2'b00);
		pulse(GATE1 | FORCE1);
		check("gate_beats_force", {m_g, m_f}, 2'b10);
		pulse(DIS);
		check("disable_mode", {m_g, m_f}, 2'b00);
		// Trigger pin already high at launch: only a fresh rising edge may start the program
		pin(1'b0, 1'b1);
		trg_en <= 1'b1;
		idle(5);
		pulse(GO);
		check("armed", {run, wt, st}, 3'b110);
		pin(1'b0, 1'b0);
		idle(8);
		check("fall_ignored", {run, wt, st}, 3'b110);
		pin(1'b0, 1'b1);
		n = 0;
		while (st !== 1'b1 && n < 12)
		begin
			idle(1);
			n++;
		end
		check("started", {run, st}, 2'b11);
		idle(1);
		check("start_once", {run, wt, st}, 3'b100);
		pulse(HALT);
		trg_en <= 1'b0;
		pulse(GO);
		check("no_ext_trig", {run, wt, st}, 3'b101);
		pulse(HALT);
		check("halted", run, 1'b0);
		// The output is still off here, left so by the off request before forcing; lock does not gate it
		check("en_before_lock", en, 1'b0);
		pulse(RNGW);
		rper <= REF_PER;
		idle(3);
		check("free_run", fw, TGT);
		// Offset taken from free-run phase at a reference edge, so lock needs no phase pull
		@(posedge sref);
		idle(3);
		offv = {pa, 16'h0000};
		@(posedge clk);
		{ph_off, sync_en, mon} <= {offv, 2'b11};
		n = 0;
		while (lk !== 1'b1 && n < 40000)
		begin
			idle(1);
			n++;
		end
		check("locked", {lk, ulk}, 2'b10);
		k = 0;
		repeat (2 * SPER)
		begin
			idle(1);
			k += (show === 1'b1);
		end
		check("show_slots", k, 2 * SON);
		@(posedge clk);
		rper <= 16'h0000;
		n = 0;
		while (ulk !== 1'b1 && n < TMO + REF_PER + 50)
		begin
			idle(1);
			n++;
		end
		check("ref_lost", {lk, ulk}, 2'b01);
		// The locked slot lags lock status by one cycle
		idle(1);
		check("show_off", show, 1'b0);
		check("lost_delay", n > TMO - REF_PER - 10, 1'b1);
		wrap_up();
	end
endmodule : tb_aux_input_sync_control
